// file: include/sim_pkg.sv
// Package with register map, field positions and codes of the socket block.
package sim_pkg;
    // ==========================================================
    // Register byte addresses.
    localparam logic [23:0] ADDR_SUMMARY   = 24'hFE0034;
    localparam logic [23:0] ADDR_MASK      = 24'hFE0016;
    localparam logic [23:0] ADDR_MODE_BASE = 24'hFE4000;
    localparam logic [23:0] ADDR_FLAG_BASE = 24'hFE4002;
    localparam logic [23:0] ADDR_SOCK_STEP = 24'h000100;
    localparam logic [23:0] ADDR_STATUS    = 24'hFE0038;
    localparam logic [23:0] ADDR_CMD_BASE  = 24'hFE4001;
    // ==========================================================
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ==========================================================
    // Mode register field positions.
    localparam int MODE_MULTI_BIT = 7;
    localparam int MODE_MACF_BIT  = 6;
    localparam int MODE_NDMC_BIT  = 5;
    localparam int MODE_PROTO_MSB = 3;
    // ==========================================================
    // Protocol codes.
    localparam logic [3:0] PROTO_CLOSED  = 4'h0;
    localparam logic [3:0] PROTO_TCP     = 4'h1;
    localparam logic [3:0] PROTO_UDP     = 4'h2;
    localparam logic [3:0] PROTO_IP_RAW  = 4'h3;
    localparam logic [3:0] PROTO_MAC_RAW = 4'h4;
    localparam logic [3:0] PROTO_PPPOE   = 4'h5;
    // ==========================================================
    // Open command and opened-state codes.
    localparam logic [7:0] CMD_OPEN        = 8'h01;
    localparam logic [7:0] STATE_CLOSED    = 8'h00;
    localparam logic [7:0] STATE_TCP_INIT  = 8'h13;
    localparam logic [7:0] STATE_UDP       = 8'h22;
    localparam logic [7:0] STATE_IP_RAW    = 8'h32;
    localparam logic [7:0] STATE_MAC_RAW   = 8'h42;
    localparam logic [7:0] STATE_PPPOE     = 8'h5F;
endpackage

// file: rtl/sim_sock_flags.sv
// One socket's interrupt flag register with write-one-to-clear.
`timescale 1ns/1ns
module sim_sock_flags (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_event,
    input  wire logic       i_clr_we,
    input  wire logic [7:0] i_clr_data,
    output logic      [7:0] o_flags,
    output logic            o_any
);
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;

    // Set wins over clear so an event in the clearing cycle survives.
    always_comb begin
        nxt_flags = flags_ff;
        if (i_clr_we) begin
            nxt_flags = nxt_flags & ~i_clr_data;
        end
        nxt_flags = nxt_flags | i_event;
    end

    // Register the flags.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            flags_ff <= sim_pkg::RST_BYTE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign o_flags = flags_ff;
    assign o_any   = |flags_ff;
endmodule

// file: rtl/sim_sock_mode.sv
// One socket's mode register, option decode and open-state selection.
`timescale 1ns/1ns
module sim_sock_mode #(
    parameter bit IS_SOCK0 = 1'b0
) (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_open,
    output logic      [7:0] o_mode,
    output logic      [7:0] o_state,
    output logic            o_multicast,
    output logic            o_mac_filter,
    output logic            o_nodelay_ack,
    output logic            o_igmp_v1
);
    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic [7:0] state_ff;
    logic [7:0] nxt_state;
    logic [3:0] protocol_select;

    assign protocol_select = mode_ff[sim_pkg::MODE_PROTO_MSB:0];

    // MAC raw and PPPoE codes only stick on socket 0; others fall to closed.
    always_comb begin
        nxt_mode = mode_ff;
        if (i_we) begin
            nxt_mode = i_wdata & 8'hEF;
            if (!IS_SOCK0 && (i_wdata[3:0] == sim_pkg::PROTO_MAC_RAW ||
                              i_wdata[3:0] == sim_pkg::PROTO_PPPOE)) begin
                nxt_mode[3:0] = sim_pkg::PROTO_CLOSED;
            end
        end
    end

    // Opening enters the state that matches the selected protocol.
    always_comb begin
        nxt_state = state_ff;
        if (i_open) begin
            case (protocol_select)
                sim_pkg::PROTO_TCP:     nxt_state = sim_pkg::STATE_TCP_INIT;
                sim_pkg::PROTO_UDP:     nxt_state = sim_pkg::STATE_UDP;
                sim_pkg::PROTO_IP_RAW:  nxt_state = sim_pkg::STATE_IP_RAW;
                sim_pkg::PROTO_MAC_RAW: nxt_state = sim_pkg::STATE_MAC_RAW;
                sim_pkg::PROTO_PPPOE:   nxt_state = sim_pkg::STATE_PPPOE;
                default:                nxt_state = sim_pkg::STATE_CLOSED;
            endcase
        end
    end

    // Register mode and state.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mode_ff  <= sim_pkg::RST_BYTE;
            state_ff <= sim_pkg::STATE_CLOSED;
        end else begin
            mode_ff  <= nxt_mode;
            state_ff <= nxt_state;
        end
    end

    // Option bits except MAC filter only mean something in their own protocol.
    assign o_mode        = mode_ff;
    assign o_state       = state_ff;
    assign o_multicast   = mode_ff[sim_pkg::MODE_MULTI_BIT] &&
                           protocol_select == sim_pkg::PROTO_UDP;
    assign o_mac_filter  = mode_ff[sim_pkg::MODE_MACF_BIT];
    assign o_nodelay_ack = mode_ff[sim_pkg::MODE_NDMC_BIT] &&
                           protocol_select == sim_pkg::PROTO_TCP;
    assign o_igmp_v1     = mode_ff[sim_pkg::MODE_NDMC_BIT] &&
                           o_multicast;
endmodule

// file: rtl/sim_socket_regs.sv
// Socket interrupt summary, mask, core interrupt and mode registers.
//
// What this block does
// - Socket interrupt sets its summary bit.
// - Interrupt pin low while any unmasked summary bit set.
// - Summary bit clears when socket flags cleared.
// - Mode bit 7 enables multicast, UDP only.
// - TCP: bit 5 forces immediate ACK.
// - UDP multicast: bit 5 picks IGMP v1.
// - Bits 3..0 protocol; MAC raw/PPPoE socket 0 only.
// - Open enters state of selected protocol.
// - Mask bit gates summary onto interrupt.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module sim_socket_regs #(
    parameter int NUM_SOCK = 8
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_sys_rst,
    input  wire logic [23:0]           i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    input  wire logic [NUM_SOCK*8-1:0] i_sock_event,
    output logic                       o_core_irq_n,
    output logic                       o_core_irq_line,
    output logic      [NUM_SOCK-1:0]   o_multicast,
    output logic      [NUM_SOCK-1:0]   o_mac_filter,
    output logic      [NUM_SOCK-1:0]   o_nodelay_ack,
    output logic      [NUM_SOCK-1:0]   o_igmp_v1
);
    // ==========================================================
    // Parameter check: the summary register is one byte.
    if (NUM_SOCK != 8) begin : g_bad_num_sock
        $error("NUM_SOCK must be 8");
    end

    // ==========================================================
    // Address decode helper.
    function automatic logic hit_sock(input logic [23:0] a,
                                      input logic [23:0] base,
                                      input int          n);
        hit_sock = (a == base + 24'(n) * sim_pkg::ADDR_SOCK_STEP);
    endfunction

    logic [7:0]          mask_ff;
    logic [7:0]          nxt_mask;
    logic [7:0]          summary_ff;
    logic [7:0]          nxt_summary;
    logic [7:0]          rdata_ff;
    logic [7:0]          nxt_rdata;
    logic                irq_ff;
    logic                nxt_irq;
    logic                irq_n_ff;
    logic                nxt_irq_n;
    logic [NUM_SOCK-1:0] mc_ff;
    logic [NUM_SOCK-1:0] mf_ff;
    logic [NUM_SOCK-1:0] nd_ff;
    logic [NUM_SOCK-1:0] ig_ff;
    logic [NUM_SOCK-1:0] sock_any;
    logic [NUM_SOCK-1:0] mode_we;
    logic [NUM_SOCK-1:0] flag_we;
    logic [NUM_SOCK-1:0] open_cmd;
    logic [NUM_SOCK-1:0] mc_w;
    logic [NUM_SOCK-1:0] mf_w;
    logic [NUM_SOCK-1:0] nd_w;
    logic [NUM_SOCK-1:0] ig_w;
    logic [7:0]          flags_w [NUM_SOCK];
    logic [7:0]          mode_w  [NUM_SOCK];
    logic [7:0]          state_w [NUM_SOCK];

    // ==========================================================
    // Per-socket write strobes.
    always_comb begin
        for (int n = 0; n < NUM_SOCK; n++) begin
            mode_we[n]  = i_wr && hit_sock(i_addr, sim_pkg::ADDR_MODE_BASE, n);
            flag_we[n]  = i_wr && hit_sock(i_addr, sim_pkg::ADDR_FLAG_BASE, n);
            open_cmd[n] = i_wr && i_wdata == sim_pkg::CMD_OPEN &&
                          hit_sock(i_addr, sim_pkg::ADDR_CMD_BASE, n);
        end
    end

    // ==========================================================
    // Socket instances.
    for (genvar g = 0; g < NUM_SOCK; g++) begin : g_sock
        sim_sock_flags u_flags (
            .i_clock    (i_clock),
            .i_sys_rst  (i_sys_rst),
            .i_event    (i_sock_event[g*8 +: 8]),
            .i_clr_we   (flag_we[g]),
            .i_clr_data (i_wdata),
            .o_flags    (flags_w[g]),
            .o_any      (sock_any[g])
        );
        sim_sock_mode #(.IS_SOCK0(g == 0)) u_mode (
            .i_clock       (i_clock),
            .i_sys_rst     (i_sys_rst),
            .i_we          (mode_we[g]),
            .i_wdata       (i_wdata),
            .i_open        (open_cmd[g]),
            .o_mode        (mode_w[g]),
            .o_state       (state_w[g]),
            .o_multicast   (mc_w[g]),
            .o_mac_filter  (mf_w[g]),
            .o_nodelay_ack (nd_w[g]),
            .o_igmp_v1     (ig_w[g])
        );
    end

    // ==========================================================
    // Summary and mask. The summary is a registered copy of the flag
    // OR, so writes to it are ignored: clearing goes through the flags.
    always_comb begin
        nxt_summary = sock_any;
        nxt_mask    = mask_ff;
        if (i_wr && i_addr == sim_pkg::ADDR_MASK) begin
            nxt_mask = i_wdata;
        end
        // High while any enabled summary bit is set.
        nxt_irq = |(nxt_summary & nxt_mask);
        // The low-active pin gets its own flop so no gate follows it.
        nxt_irq_n = ~nxt_irq;
    end

    // ==========================================================
    // Read mux; unmapped addresses read zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (i_rd) begin
            if (i_addr == sim_pkg::ADDR_SUMMARY) begin
                nxt_rdata = summary_ff;
            end else if (i_addr == sim_pkg::ADDR_MASK) begin
                nxt_rdata = mask_ff;
            end else if (i_addr == sim_pkg::ADDR_STATUS) begin
                nxt_rdata = state_w[0];
            end
            for (int n = 0; n < NUM_SOCK; n++) begin
                if (hit_sock(i_addr, sim_pkg::ADDR_MODE_BASE, n)) begin
                    nxt_rdata = mode_w[n];
                end
                if (hit_sock(i_addr, sim_pkg::ADDR_FLAG_BASE, n)) begin
                    nxt_rdata = flags_w[n];
                end
                if (hit_sock(i_addr, sim_pkg::ADDR_STATUS + 24'h000004, n))
                begin
                    nxt_rdata = state_w[n];
                end
            end
        end
    end

    // ==========================================================
    // Registers. Outputs come straight from these flip-flops.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mask_ff    <= sim_pkg::RST_BYTE;
            summary_ff <= sim_pkg::RST_BYTE;
            rdata_ff   <= sim_pkg::RST_BYTE;
            irq_ff     <= 1'b0;
            irq_n_ff   <= 1'b1;
            mc_ff      <= '0;
            mf_ff      <= '0;
            nd_ff      <= '0;
            ig_ff      <= '0;
        end else begin
            mask_ff    <= nxt_mask;
            summary_ff <= nxt_summary;
            rdata_ff   <= nxt_rdata;
            irq_ff     <= nxt_irq;
            irq_n_ff   <= nxt_irq_n;
            mc_ff      <= mc_w;
            mf_ff      <= mf_w;
            nd_ff      <= nd_w;
            ig_ff      <= ig_w;
        end
    end

    assign o_rdata         = rdata_ff;
    assign o_core_irq_line = irq_ff;
    assign o_core_irq_n    = irq_n_ff;
    assign o_multicast     = mc_ff;
    assign o_mac_filter    = mf_ff;
    assign o_nodelay_ack   = nd_ff;
    assign o_igmp_v1       = ig_ff;
endmodule

// file: verif/sim_host_model.sv
// Host processor model issuing register cycles on the plain port.
`timescale 1ns/1ns
module sim_host_model (
    input  wire logic        i_clock,
    output logic      [23:0] o_addr,
    output logic      [7:0]  o_wdata,
    output logic             o_wr,
    output logic             o_rd,
    input  wire logic [7:0]  i_rdata
);
    // ==========================================================
    // Idle state; released data turns inverse so stale bytes never pass.
    initial begin
        o_addr = 24'h000000;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One write cycle; group setup for multicast lives outside.
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // Flags are cleared only through the socket's own flag register.
    task automatic clr(input int n, input logic [7:0] bits);
        wr(sim_pkg::ADDR_FLAG_BASE + sim_pkg::ADDR_SOCK_STEP * 24'(n),
           bits);
    endtask
    // One read cycle; data is taken in the cycle after the strobe.
    task automatic rd(input logic [23:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule

// file: verif/sim_socket_regs_monitor.sv
// Checker of interrupt summary, mask gating and mode option outputs.
`timescale 1ns/1ns
module sim_socket_regs_monitor #(
    parameter int NUM_SOCK = 8
) (
    input wire logic                  i_clock,
    input wire logic                  i_sys_rst,
    input wire logic [23:0]           i_addr,
    input wire logic [7:0]            i_wdata,
    input wire logic                  i_wr,
    input wire logic                  i_rd,
    input wire logic [7:0]            o_rdata,
    input wire logic [NUM_SOCK*8-1:0] i_sock_event,
    input wire logic                  o_core_irq_n,
    input wire logic                  o_core_irq_line,
    input wire logic [NUM_SOCK-1:0]   o_multicast,
    input wire logic [NUM_SOCK-1:0]   o_mac_filter,
    input wire logic [NUM_SOCK-1:0]   o_nodelay_ack,
    input wire logic [NUM_SOCK-1:0]   o_igmp_v1
);
    // ==========================================================
    // Shadow state
    logic [NUM_SOCK-1:0] mask_ff, nxt_mask, udp_ff, nxt_udp;
    logic [NUM_SOCK-1:0] tcp_ff, nxt_tcp, ev_any;
    // Shadows follow host writes, so gating is judged without internals.
    always_comb begin
        nxt_mask = mask_ff;
        nxt_udp = udp_ff;
        nxt_tcp = tcp_ff;
        if (i_wr && i_addr == sim_pkg::ADDR_MASK) begin
            nxt_mask = i_wdata[NUM_SOCK-1:0];
        end
        for (int n = 0; n < NUM_SOCK; n++) begin
            ev_any[n] = |i_sock_event[8*n +: 8];
            if (i_wr && i_addr == sim_pkg::ADDR_MODE_BASE
                + sim_pkg::ADDR_SOCK_STEP * 24'(n)) begin
                nxt_udp[n] = i_wdata[3:0] == sim_pkg::PROTO_UDP;
                nxt_tcp[n] = i_wdata[3:0] == sim_pkg::PROTO_TCP;
            end
        end
    end
    // Registers of the shadows, cleared like the block itself.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mask_ff <= '0;
            udp_ff <= '0;
            tcp_ff <= '0;
        end else begin
            mask_ff <= nxt_mask;
            udp_ff <= nxt_udp;
            tcp_ff <= nxt_tcp;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    chk_mask_quiet: assert property (
        mask_ff == '0 && $past(mask_ff) == '0 |-> o_core_irq_n)
        else $error("core irq low while all masked");
    chk_event_irq: assert property (
        |(ev_any & mask_ff) |-> ##[2:4] !o_core_irq_n)
        else $error("unmasked event gave no core irq");
    chk_irq_release: assert property (
        $rose(o_core_irq_n) |-> $past(i_wr) || $past(i_wr, 2)
        || $past(i_wr, 3) || $past(i_wr, 4))
        else $error("core irq released with no host write");
    chk_rd_quiet: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_mc_udp: assert property (
        (o_multicast & ~(udp_ff | $past(udp_ff))) == '0)
        else $error("multicast outside udp");
    chk_nd_tcp: assert property (
        (o_nodelay_ack & ~(tcp_ff | $past(tcp_ff))) == '0)
        else $error("no delay ack outside tcp");
    chk_igmp_mc: assert property (
        (o_igmp_v1 & ~o_multicast) == '0)
        else $error("igmp version one without multicast");
    chk_mf_write: assert property (
        i_wr && i_addr == sim_pkg::ADDR_MODE_BASE |-> ##2
        o_mac_filter[0] == $past(i_wdata[sim_pkg::MODE_MACF_BIT], 2))
        else $error("mac filter did not follow mode write");
endmodule
bind sim_socket_regs sim_socket_regs_monitor #(.NUM_SOCK(NUM_SOCK)) mon_u (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sock_event(i_sock_event), .o_core_irq_n(o_core_irq_n),
    .o_core_irq_line(o_core_irq_line), .o_multicast(o_multicast),
    .o_mac_filter(o_mac_filter), .o_nodelay_ack(o_nodelay_ack),
    .o_igmp_v1(o_igmp_v1));

// file: verif/socket_irq_summary_and_mode_bench.sv
// Self-checking bench of the socket summary and mode registers.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module socket_irq_summary_and_mode_bench;
    logic        clk = 1'b0, rst = 1'b1, wr, rd, irq_n, irq_line;
    logic [23:0] addr;
    logic [7:0]  wdata, rdata, mc, mf, nd, ig;
    logic [63:0] ev = 64'h0;
    int          err_total = 0, checks = 0;
    // ==========================================================
    // Clock and instances
    always #5 clk = ~clk;
    sim_socket_regs #(.NUM_SOCK(8)) dut_u (.i_clock(clk), .i_sys_rst(rst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_sock_event(ev), .o_core_irq_n(irq_n),
        .o_core_irq_line(irq_line), .o_multicast(mc), .o_mac_filter(mf),
        .o_nodelay_ack(nd), .o_igmp_v1(ig));
    sim_host_model host_u (.i_clock(clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
    // ==========================================================
    // Helpers
    function automatic logic [23:0] sa(input logic [23:0] b, input int n);
        return b + sim_pkg::ADDR_SOCK_STEP * 24'(n);
    endfunction
    task automatic pulse(input int s, input int b);
        @(posedge clk);
        ev[8*s+b] <= 1'b1;
        @(posedge clk);
        ev <= 64'h0;
    endtask
    task automatic conclude();
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] d;
        host_u.wr(24'hFE00FF, 8'hFF);
        host_u.rd(24'hFE00FF, d);
        `CHK(d, 8'h00)
        host_u.rd(sim_pkg::ADDR_SUMMARY, d);
        `CHK(d, sim_pkg::RST_BYTE)
        host_u.rd(sim_pkg::ADDR_MASK, d);
        `CHK(d, sim_pkg::RST_BYTE)
        host_u.rd(sim_pkg::ADDR_MODE_BASE, d);
        `CHK(d, sim_pkg::RST_BYTE)
        `CHK({irq_n, irq_line, mf}, 10'h200)
        // With every mask bit low an event shows in the summary only.
        pulse(5, 1);
        repeat (3) @(posedge clk);
        host_u.rd(sim_pkg::ADDR_SUMMARY, d);
        `CHK(d, 8'h20)
        `CHK({irq_n, irq_line}, 2'h2)
        host_u.clr(5, 8'h02);
    endtask
    // Two sockets raise, then clear one at a time; summary is not writable.
    task automatic t_irq();
        logic [7:0] d;
        host_u.wr(sim_pkg::ADDR_MASK, 8'hFF);
        pulse(3, 2);
        pulse(7, 0);
        repeat (3) @(posedge clk);
        host_u.rd(sim_pkg::ADDR_SUMMARY, d);
        `CHK({d, irq_n}, 9'h110)
        host_u.clr(3, 8'h04);
        repeat (3) @(posedge clk);
        host_u.rd(sim_pkg::ADDR_SUMMARY, d);
        `CHK({d, irq_n}, 9'h100)
        host_u.clr(7, 8'h01);
        host_u.wr(sim_pkg::ADDR_SUMMARY, 8'hFF);
        repeat (3) @(posedge clk);
        host_u.rd(sim_pkg::ADDR_SUMMARY, d);
        `CHK({d, irq_n}, 9'h001)
    endtask
    // A masked socket sets its summary bit but not the core line.
    task automatic t_mask();
        logic [7:0] d;
        host_u.wr(sim_pkg::ADDR_MASK, 8'hFD);
        pulse(1, 7);
        repeat (3) @(posedge clk);
        host_u.rd(sim_pkg::ADDR_SUMMARY, d);
        `CHK({d, irq_n}, 9'h005)
        host_u.wr(sim_pkg::ADDR_MASK, 8'h02);
        repeat (3) @(posedge clk);
        `CHK({irq_n, irq_line}, 2'h1)
        host_u.clr(1, 8'h80);
        repeat (3) @(posedge clk);
        `CHK({irq_n, irq_line}, 2'h2)
    endtask
    // Every protocol on sockets 0 and 1; bit 4 is written high in every loop pass, low in the final 8'h22 write.
    task automatic t_modes();
        logic [7:0] d, st[6];
        logic [3:0] q;
        st = '{sim_pkg::STATE_CLOSED, sim_pkg::STATE_TCP_INIT,
            sim_pkg::STATE_UDP, sim_pkg::STATE_IP_RAW,
            sim_pkg::STATE_MAC_RAW, sim_pkg::STATE_PPPOE};
        for (int p = 0; p < 6; p++) begin
            q = (p > 3) ? 4'h0 : 4'(p);
            host_u.wr(sim_pkg::ADDR_MODE_BASE, 8'hF0 | 8'(p));
            host_u.wr(sa(sim_pkg::ADDR_MODE_BASE, 1), 8'hF0 | 8'(p));
            host_u.wr(sim_pkg::ADDR_CMD_BASE, sim_pkg::CMD_OPEN);
            host_u.rd(sa(sim_pkg::ADDR_MODE_BASE, 1), d);
            `CHK(d, {4'hE, q})
            host_u.rd(sim_pkg::ADDR_STATUS, d);
            `CHK(d, st[p])
            host_u.wr(sa(sim_pkg::ADDR_CMD_BASE, 1), sim_pkg::CMD_OPEN);
            host_u.rd(sa(sim_pkg::ADDR_STATUS + 24'h000004, 1), d);
            `CHK(d, st[q])
            `CHK({mc[1:0], ig[1:0]}, {4{p == 2}})
            `CHK({nd[1:0], mf[1:0]}, {{2{p == 1}}, 2'h3})
        end
        host_u.wr(sim_pkg::ADDR_MODE_BASE, 8'h22);
        repeat (3) @(posedge clk);
        `CHK({mc[0], ig[0], nd[0], mf[0]}, 4'h0)
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_irq();
        t_mask();
        t_modes();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        conclude();
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule
